// >>> src/rss_top.sv
// Relay scan sequencer with an AHB-Lite register slave.
// Assumes a single-word AHB-Lite master on core_clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module rss_top #(
    parameter int LDEP        = 64,
    parameter int CYC_PER_US  = rss_pkg::CYC_PER_US,
    parameter int ENC_WAIT_US = rss_pkg::ENC_WAIT_MS * rss_pkg::US_PER_MS,
    parameter int ENC_LOW_US  = rss_pkg::ENC_LOW_MS * rss_pkg::US_PER_MS
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // Backplane and front panel pins
    input  wire logic                      backplane_trigger_in_two_n,
    input  wire logic                      power_fail_n,
    output logic                           backplane_trigger_out_one_n,
    output logic      [rss_pkg::NSEC-1:0]  encode_n,
    // Relay drive
    output logic                           relay_closed,
    output logic      [rss_pkg::MOD_W-1:0] relay_module,
    output logic      [rss_pkg::SEC_W-1:0] relay_section,
    output logic      [rss_pkg::CH_W-1:0]  relay_channel,
    // Interrupt
    output logic                           irq
);
    localparam int IW = $clog2(LDEP);
    localparam int UW = $clog2(CYC_PER_US);
    localparam logic [UW-1:0] US_LAST = UW'(CYC_PER_US - 1);
    localparam logic [31:0] ENC_WAIT = 32'(ENC_WAIT_US);
    localparam logic [31:0] ENC_LOW  = 32'(ENC_LOW_US);
    localparam int EW = rss_pkg::ENT_W;
    localparam int MW = rss_pkg::MOD_W;

    // Bus side registers
    logic [31:0]              hrdata_q;
    logic                     wr_q;
    logic [11:0]              wa_q;
    logic [rss_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0]              count_q;
    logic [31:0]              tdly_q;
    logic [IW:0]              len_q;
    logic [31:0]              odw_q [rss_pkg::NMOD];
    logic [31:0]              cdw_q [rss_pkg::NMOD];
    logic [1:0]               cfg_q [rss_pkg::NMOD];
    logic [EW-1:0]            list_q [LDEP];
    logic [rss_pkg::EV_W-1:0] stat_q;
    logic [rss_pkg::EV_W-1:0] mask_q;
    logic                     irq_q;

    // Sequencer registers
    rss_pkg::rss_state_t      st_q;
    rss_pkg::rss_state_t      st_d;
    logic [31:0]              tmr_q;
    logic [UW-1:0]            us_q;
    logic [IW-1:0]            idx_q;
    logic [15:0]              pass_q;
    logic                     rly_q;
    logic [MW-1:0]            rmod_q;
    logic [rss_pkg::SEC_W-1:0] rsec_q;
    logic [rss_pkg::CH_W-1:0] rch_q;
    logic                     trg_n_q;
    logic [rss_pkg::NSEC-1:0] enc_n_q;

    // Pin synchronisers
    logic                     bp1_q;
    logic                     bp2_q;
    logic                     bp3_q;
    logic                     pf1_q;
    logic                     pf2_q;

    // Bus decode
    wire        acc    = hsel & htrans[1] & hready;
    wire        rd_acc = acc & ~hwrite;
    wire        a_ok   = (haddr[31:12] == 20'h0);
    wire [11:0] ra     = haddr[11:0];
    wire        w_ctrl = wr_q & (wa_q == rss_pkg::A_CTRL);
    wire        w_cnt  = wr_q & (wa_q == rss_pkg::A_COUNT);
    wire        w_tdly = wr_q & (wa_q == rss_pkg::A_TDLY);
    wire        w_len  = wr_q & (wa_q == rss_pkg::A_LEN);
    wire        w_cfg  = wr_q & (wa_q == rss_pkg::A_CFG);
    wire        w_mask = wr_q & (wa_q == rss_pkg::A_MASK);
    wire        w_odw  = wr_q & (wa_q[11:4] == rss_pkg::A_ODW);
    wire        w_cdw  = wr_q & (wa_q[11:4] == rss_pkg::A_CDW);
    wire        w_list = wr_q & (wa_q[11:8] == rss_pkg::A_LIST);
    wire [MW-1:0] wmod = wa_q[MW+1:2];
    wire [IW-1:0] widx = wa_q[IW+1:2];
    wire        rd_stat = rd_acc & a_ok & (ra == rss_pkg::A_STAT);

    // Command strobes from a control write, and fields of the control register
    wire       cmd_init  = w_ctrl & hwdata[rss_pkg::C_INIT];
    wire       cmd_abort = w_ctrl & hwdata[rss_pkg::C_ABORT];
    wire       cmd_bus   = w_ctrl & hwdata[rss_pkg::C_BUS];
    wire       cont      = ctrl_q[rss_pkg::C_CONT];
    wire       tout_en   = ctrl_q[rss_pkg::C_TOUT];
    wire [1:0] src       = ctrl_q[rss_pkg::C_SRC+1:rss_pkg::C_SRC];
    wire       opc_req   = ctrl_q[rss_pkg::C_OPC];
    wire       pf_open   = ctrl_q[rss_pkg::C_PFO];

    // Configuration write hits the module of the closed relay
    wire [MW-1:0] cfg_mod = hwdata[MW-1:0];
    wire          cfg_hit = w_cfg & (cfg_mod == rmod_q);
    wire          pf_fail = ~pf2_q;

    // Entry field extraction
    function automatic logic [MW-1:0] ent_mod(input logic [EW-1:0] e);
        ent_mod = e[EW-1:EW-MW];
    endfunction

    // Trigger qualification
    wire bp_fall = bp3_q & ~bp2_q;
    wire go = (src == rss_pkg::SRC_IMM)
            | ((src == rss_pkg::SRC_BUS) & cmd_bus)
            | ((src == rss_pkg::SRC_BP2) & bp_fall);
    wire us_tick  = (us_q == US_LAST);
    wire tmr_zero = (tmr_q == 32'h0);
    wire [EW-1:0] nxt_ent = list_q[idx_q];
    wire last_ent = ({1'b0, idx_q} == len_q - 1'b1);
    wire [15:0] pass_n = pass_q + 16'h1;
    wire all_done = ~cont & (pass_n >= count_q);
    wire step_end = (st_q == rss_pkg::S_ENCL) & tmr_zero;
    wire scan_end = step_end & last_ent & all_done;

    // Event sources, set wins over read clear
    wire [rss_pkg::EV_W-1:0] ev;
    assign ev[rss_pkg::EV_STEP] = step_end;
    assign ev[rss_pkg::EV_DONE] = scan_end & opc_req; // R12
    assign ev[rss_pkg::EV_PASS] = step_end & last_ent;
    wire [rss_pkg::EV_W-1:0] stat_d = (rd_stat ? '0 : stat_q) | ev;

    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            rss_pkg::S_IDLE:   if (cmd_init && len_q != '0) st_d = rss_pkg::S_ARM;
            rss_pkg::S_ARM:    if (go) st_d = rss_pkg::S_TDLY; // R1 R10 R16
            rss_pkg::S_TDLY:   if (tmr_zero) st_d = rss_pkg::S_OPENW; // R2
            rss_pkg::S_OPENW:  if (tmr_zero) st_d = rss_pkg::S_CLOSEW; // R3
            rss_pkg::S_CLOSEW: if (tmr_zero) st_d = rss_pkg::S_TRIGP; // R4
            rss_pkg::S_TRIGP:  st_d = rss_pkg::S_ENCW;
            rss_pkg::S_ENCW:   if (tmr_zero) st_d = rss_pkg::S_ENCL;
            rss_pkg::S_ENCL:   if (tmr_zero) begin
                st_d = scan_end ? rss_pkg::S_IDLE : rss_pkg::S_ARM; // R11 R13
            end
            default:           st_d = rss_pkg::S_IDLE;
        endcase
        if (cmd_abort) begin
            st_d = rss_pkg::S_IDLE; // R14
        end
    end

    // Read data mux
    logic [31:0] rdat;
    always_comb begin
        rdat = 32'h0;
        case (ra)
            rss_pkg::A_CTRL:  rdat = {24'h0, ctrl_q};
            rss_pkg::A_COUNT: rdat = {16'h0, count_q};
            rss_pkg::A_TDLY:  rdat = tdly_q;
            rss_pkg::A_LEN:   rdat = 32'(len_q);
            rss_pkg::A_CFG:   rdat = {24'h0, cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
            rss_pkg::A_STAT:  rdat = 32'(stat_q);
            rss_pkg::A_MASK:  rdat = 32'(mask_q);
            rss_pkg::A_STATE: rdat = {pass_q, 4'h0, rly_q, st_q, 2'h0, 6'(idx_q)};
            default: begin
                if (ra[11:4] == rss_pkg::A_ODW) rdat = odw_q[ra[MW+1:2]];
                else if (ra[11:4] == rss_pkg::A_CDW) rdat = cdw_q[ra[MW+1:2]];
                else if (ra[11:8] == rss_pkg::A_LIST) rdat = 32'(list_q[ra[IW+1:2]]);
            end
        endcase
        if (!a_ok) begin
            rdat = 32'h0;
        end
    end

    // Bus slave: zero wait, read data captured at the address phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata_q <= 32'h0;
            wr_q     <= 1'b0;
            wa_q     <= 12'h0;
        end else begin
            wr_q <= acc & hwrite & a_ok & (hsize == 3'h2);
            wa_q <= ra;
            if (rd_acc) hrdata_q <= rdat;
        end
    end

    // Software settings
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= rss_pkg::CTRL_RST;
            count_q <= 16'h1;
            tdly_q  <= 32'h0;
            len_q   <= '0;
            mask_q  <= '0;
        end else begin
            if (w_ctrl) ctrl_q <= hwdata[rss_pkg::CTRL_W-1:0];
            if (w_cnt) count_q <= hwdata[15:0];
            if (w_tdly) tdly_q <= hwdata;
            if (w_len) len_q <= hwdata[IW:0];
            if (w_mask) mask_q <= hwdata[rss_pkg::EV_W-1:0];
        end
    end

    // Per module dwell and section configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int m = 0; m < rss_pkg::NMOD; m++) begin
                odw_q[m] <= 32'h0;
                cdw_q[m] <= 32'h0;
                cfg_q[m] <= 2'h0;
            end
        end else begin
            if (w_odw) odw_q[wmod] <= hwdata;
            if (w_cdw) cdw_q[wmod] <= hwdata;
            if (w_cfg) cfg_q[cfg_mod] <= hwdata[3:2];
        end
    end

    // List entries hold no control state
    always_ff @(posedge core_clk) begin
        if (w_list) list_q[widx] <= hwdata[EW-1:0];
    end

    // Sticky status and interrupt
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
        end
    end

    // Pin synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bp1_q <= 1'b1;
            bp2_q <= 1'b1;
            bp3_q <= 1'b1;
            pf1_q <= 1'b1;
            pf2_q <= 1'b1;
        end else begin
            bp1_q <= backplane_trigger_in_two_n;
            bp2_q <= bp1_q;
            bp3_q <= bp2_q;
            pf1_q <= power_fail_n;
            pf2_q <= pf1_q;
        end
    end

    // Microsecond tick divider
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) us_q <= '0;
        else us_q <= us_tick ? '0 : us_q + 1'b1;
    end

    // Step timer, loaded on every state change
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tmr_q <= 32'h0;
        end else if (st_d != st_q) begin
            case (st_d)
                rss_pkg::S_TDLY:   tmr_q <= tdly_q; // R2
                rss_pkg::S_OPENW:  tmr_q <= odw_q[rmod_q]; // R3 R15
                rss_pkg::S_CLOSEW: tmr_q <= cdw_q[ent_mod(nxt_ent)]; // R4 R15
                rss_pkg::S_ENCW:   tmr_q <= ENC_WAIT; // R6
                rss_pkg::S_ENCL:   tmr_q <= ENC_LOW; // R6
                default:           tmr_q <= 32'h0;
            endcase
        end else if (us_tick && !tmr_zero) begin
            tmr_q <= tmr_q - 32'h1;
        end
    end

    // List position and pass count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx_q  <= '0;
            pass_q <= 16'h0;
        end else if (st_q == rss_pkg::S_IDLE && st_d == rss_pkg::S_ARM) begin
            idx_q  <= '0;
            pass_q <= 16'h0;
        end else if (step_end && !cmd_abort) begin
            idx_q <= last_ent ? '0 : idx_q + 1'b1; // R15
            if (last_ent) pass_q <= pass_n; // R11
        end
    end

    // Relay state: open, close, forced opens
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rly_q  <= 1'b0;
            rmod_q <= '0;
            rsec_q <= '0;
            rch_q  <= '0;
        end else begin
            if (st_q == rss_pkg::S_TDLY && st_d == rss_pkg::S_OPENW) begin
                rly_q <= 1'b0; // R3
            end
            if (st_q == rss_pkg::S_OPENW && st_d == rss_pkg::S_CLOSEW) begin
                rly_q  <= 1'b1; // R4
                rmod_q <= ent_mod(nxt_ent);
                rsec_q <= nxt_ent[EW-MW-1:rss_pkg::CH_W];
                rch_q  <= nxt_ent[rss_pkg::CH_W-1:0];
            end
            if (cfg_hit) rly_q <= 1'b0; // R8
            if (pf_fail && pf_open) rly_q <= 1'b0; // R9
        end
    end

    // Trigger output and encode lines follow the next state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trg_n_q <= 1'b1;
            enc_n_q <= '1;
        end else begin
            trg_n_q <= ~(st_d == rss_pkg::S_TRIGP && tout_en); // R5 R7
            enc_n_q <= (st_d == rss_pkg::S_ENCL) ? ~(8'h01 << rsec_q) : '1; // R6
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) st_q <= rss_pkg::S_IDLE;
        else st_q <= st_d;
    end

    // Outputs
    assign hrdata                      = hrdata_q;
    assign hreadyout                   = 1'b1;
    assign hresp                       = 1'b0;
    assign backplane_trigger_out_one_n = trg_n_q;
    assign encode_n                    = enc_n_q;
    assign relay_closed                = rly_q;
    assign relay_module                = rmod_q;
    assign relay_section               = rsec_q;
    assign relay_channel               = rch_q;
    assign irq                         = irq_q;

    // Checks
    a_trig_off: assert property (@(posedge core_clk) disable iff (rst) // R7
        (st_q == rss_pkg::S_TRIGP && !tout_en) |-> trg_n_q)
        else $error("trigger out pulsed while disabled");
    a_trig_pulse: assert property (@(posedge core_clk) disable iff (rst) // R5
        (st_q == rss_pkg::S_TRIGP && tout_en) |-> !trg_n_q ##1 trg_n_q)
        else $error("trigger out pulse not one cycle");
    a_delay_hold: assert property (@(posedge core_clk) disable iff (rst) // R2
        (st_q == rss_pkg::S_TDLY && st_d == rss_pkg::S_TDLY && !cfg_hit && !pf_fail)
        |=> $stable(rly_q))
        else $error("relay moved during trigger delay");
    a_open_first: assert property (@(posedge core_clk) disable iff (rst) // R3
        (st_q == rss_pkg::S_TDLY ##1 st_q == rss_pkg::S_OPENW) |-> !rly_q)
        else $error("relay not opened after delay");
    a_close_next: assert property (@(posedge core_clk) disable iff (rst) // R4
        (st_q == rss_pkg::S_OPENW ##1 st_q == rss_pkg::S_CLOSEW) |-> rly_q)
        else $error("next relay not closed");
    a_abort_idle: assert property (@(posedge core_clk) disable iff (rst) // R14
        cmd_abort |=> st_q == rss_pkg::S_IDLE)
        else $error("abort did not idle");
    a_cfg_open: assert property (@(posedge core_clk) disable iff (rst) // R8
        cfg_hit |=> !rly_q)
        else $error("config change left relay closed");
    a_pf_open: assert property (@(posedge core_clk) disable iff (rst) // R9
        (pf_fail && pf_open) |=> !rly_q)
        else $error("power fail open ignored");
    a_enc_low: assert property (@(posedge core_clk) disable iff (rst) // R6
        (st_q == rss_pkg::S_ENCL) |-> !encode_n[rsec_q])
        else $error("encode line not low");
    a_done_end: assert property (@(posedge core_clk) disable iff (rst) // R12
        $rose(stat_q[rss_pkg::EV_DONE]) |-> $past(st_q) == rss_pkg::S_ENCL)
        else $error("completion flag set mid scan");
    a_trig_ignore: assert property (@(posedge core_clk) disable iff (rst) // R16
        (st_q == rss_pkg::S_ENCW && bp_fall && !cmd_abort) |=> st_q != rss_pkg::S_TDLY)
        else $error("trigger accepted during a step");
endmodule
`default_nettype wire

// >>> src/rss_pkg.sv
// Constants, register map and types of the relay scan sequencer.
// Assumes one 250 MHz clock; used by rss_top only through rss_pkg::name.
//
// Summary of operation
// R1 - With backplane line two as source, each low pulse starts one scan step.
// R2 - Every step first waits the programmed trigger delay before touching relays.
// R3 - Then the closed relay opens and the open dwell of its module runs.
// R4 - Then the next list relay closes and its module's close dwell runs.
// R5 - Then backplane trigger output one pulses low for 3 ns; the code drives it low for one 4 ns clock cycle.
// R6 - 5 ms later the section's encode outputs go low for 4 ms.
// R7 - Trigger output one pulses only after software enabled it.
// R8 - Changing a module's section configuration opens every channel of that module.
// R9 - On power fail relays either stay or all open, per selected action.
// R10 - Immediate source steps through the list without waiting for triggers.
// R11 - One initiate traverses the whole list the programmed count, then stops.
// R12 - Completion flag sets only after all passes end, when requested.
// R13 - Continuous mode repeats the list until abort.
// R14 - Abort stops stepping at once and returns trigger control to idle.
// R15 - Every list entry is stepped, using its own module's dwell settings.
// R16 - Triggers during a step are ignored until the encode pulse ends.
package rss_pkg;
    // Clock and timing
    localparam int CLK_MHZ      = 250;
    localparam int CLK_NS       = 4;
    localparam int CYC_PER_US   = CLK_MHZ;
    localparam int TRG_PULSE_NS = 3;
    localparam int TRG_CYC_RAW  = (TRG_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRG_CYC      = (TRG_CYC_RAW < 1) ? 1 : TRG_CYC_RAW;
    localparam int ENC_WAIT_MS  = 5;
    localparam int ENC_LOW_MS   = 4;
    localparam int US_PER_MS    = 1000;
    // Geometry
    localparam int NMOD  = 4;
    localparam int MOD_W = 2;
    localparam int SEC_W = 3;
    localparam int CH_W  = 6;
    localparam int ENT_W = MOD_W + SEC_W + CH_W;
    localparam int NSEC  = 8;
    // Register byte offsets
    localparam logic [11:0] A_CTRL  = 12'h000;
    localparam logic [11:0] A_COUNT = 12'h004;
    localparam logic [11:0] A_TDLY  = 12'h008;
    localparam logic [11:0] A_LEN   = 12'h00c;
    localparam logic [11:0] A_CFG   = 12'h010;
    localparam logic [11:0] A_STAT  = 12'h014;
    localparam logic [11:0] A_MASK  = 12'h018;
    localparam logic [11:0] A_STATE = 12'h01c;
    localparam logic [7:0]  A_ODW   = 8'h02;
    localparam logic [7:0]  A_CDW   = 8'h03;
    localparam logic [3:0]  A_LIST  = 4'h1;
    // Control bits
    localparam int C_INIT  = 0;
    localparam int C_CONT  = 1;
    localparam int C_ABORT = 2;
    localparam int C_TOUT  = 3;
    localparam int C_SRC   = 4;
    localparam int C_OPC   = 6;
    localparam int C_PFO   = 7;
    localparam int C_BUS   = 8;
    localparam int CTRL_W  = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // Trigger sources
    localparam logic [1:0] SRC_IMM = 2'h0;
    localparam logic [1:0] SRC_BUS = 2'h1;
    localparam logic [1:0] SRC_BP2 = 2'h2;
    // Event bits
    localparam int EV_STEP = 0;
    localparam int EV_DONE = 1;
    localparam int EV_PASS = 2;
    localparam int EV_W    = 3;
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_ARM    = 3'b001,
        S_TDLY   = 3'b010,
        S_OPENW  = 3'b011,
        S_CLOSEW = 3'b100,
        S_TRIGP  = 3'b101,
        S_ENCW   = 3'b110,
        S_ENCL   = 3'b111
    } rss_state_t;
endpackage

// >>> tb/rss_bp_model.sv
// Far-side model: backplane trigger source and supply monitor line.
// Assumes the bench calls its tasks from the core_clk domain.
`timescale 1ns/1ns
`default_nettype none
module rss_bp_model (
    // Clock
    input  wire logic core_clk,
    // Pins toward the block
    output logic      trig_n,
    output logic      pf_n
);
    // Both lines rest at their pulled-up level
    initial begin
        trig_n = 1'b1;
        pf_n   = 1'b1;
    end
    // Low trigger pulse, long enough for the synchroniser
    task automatic pulse();
        @(posedge core_clk);
        trig_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        trig_n <= 1'b1;
    endtask
    // Supply monitor level
    task automatic set_pf(input logic v);
        @(posedge core_clk);
        pf_n <= v;
    endtask
endmodule
`default_nettype wire

// >>> tb/relay_scan_sequencer_tb_top.sv
// Self-checking bench of the relay scan sequencer.
// Assumes rss_top with short microsecond and encode counts.
`timescale 1ns/1ns
`default_nettype none
module relay_scan_sequencer_tb_top;
    logic        core_clk   = 1'b0;
    logic        rst        = 1'b1;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [2:0]  hsize      = 3'h0;
    logic        hresp_w;
    logic [31:0] hwdata     = 32'h0;
    logic [7:0]  enc_q      = 8'hff;
    logic [31:0] hrdata;
    logic        hrdy;
    logic        trig_n;
    logic        pf_n;
    logic        tout_n;
    logic        rclosed;
    logic        irq;
    logic [7:0]  enc_n;
    logic [1:0]  rmod;
    logic [2:0]  rsec;
    logic [5:0]  rch;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          n_tp       = 0;
    int          n_ep       = 0;

    // Clock of 4 ns
    always #2 core_clk = ~core_clk;

    rss_top #(.CYC_PER_US(4), .ENC_WAIT_US(5), .ENC_LOW_US(4)) u_rss_top (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp_w), .backplane_trigger_in_two_n(trig_n),
        .power_fail_n(pf_n),
        .backplane_trigger_out_one_n(tout_n), .encode_n(enc_n), .relay_closed(rclosed),
        .relay_module(rmod), .relay_section(rsec), .relay_channel(rch), .irq(irq));

    rss_bp_model u_rss_bp_model (.core_clk(core_clk), .trig_n(trig_n), .pf_n(pf_n));

    // Pulse counters on trigger out and encode falls
    always @(posedge core_clk) begin
        if (tout_n === 1'b0) n_tp++;
        if ((enc_q & ~enc_n) != 8'h0) n_ep++;
        enc_q <= enc_n;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address phase held until hready
    task automatic aph(input logic [31:0] a, input logic w);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge core_clk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        do @(posedge core_clk); while (hrdy !== 1'b1);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        aph(a, 1'b0);
        do @(posedge core_clk); while (hrdy !== 1'b1);
        d = hrdata;
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        for (int i = 0; i < 600; i++) begin
            rd(32'h01c, s);
            if (s[10:8] === 3'h0) break;
        end
    endtask

    task automatic t_reset();
        logic [31:0] d;
        rd(32'h000, d); chk(d, 32'h0);
        rd(32'h004, d); chk(d, 32'h1);
        rd(32'h040, d); chk(d, 32'h0);
        chk({irq, rclosed, tout_n, enc_n}, 32'h1ff);
        chk({hrdy, hresp_w}, 32'h2);
    endtask

    // One triggered step: us is the sum of delay and dwells
    task automatic step(input int us, input logic [10:0] e);
        int c;
        u_rss_bp_model.pulse();
        c = 4;
        while (tout_n !== 1'b0 && c < 600) begin
            @(posedge core_clk);
            c++;
        end
        chk(c >= us * 4 && c <= us * 4 + 28, 1);
        chk({rclosed, rmod, rsec, rch}, {1'b1, e});
        @(posedge core_clk);
        chk(tout_n, 1'b1);
        fork u_rss_bp_model.pulse(); join_none
        c = 1;
        while (enc_n === 8'hff && c < 200) begin
            @(posedge core_clk);
            c++;
        end
        chk(c >= 20 && c <= 30, 1);
        chk({24'h0, ~enc_n}, 32'h1 << e[8:6]);
        c = 0;
        while (enc_n !== 8'hff && c < 200) begin
            @(posedge core_clk);
            c++;
        end
        chk(c >= 16 && c <= 22, 1);
    endtask

    task automatic t_bp();
        logic [31:0] d;
        wr(32'h020, 3); wr(32'h024, 1); wr(32'h030, 2); wr(32'h034, 6);
        wr(32'h008, 2); wr(32'h100, 32'h0c5); wr(32'h104, 32'h394);
        wr(32'h00c, 2); wr(32'h018, 2); wr(32'h000, 32'h69);
        step(7, 11'h0c5);
        repeat (60) @(posedge core_clk);
        chk(rch, 6'd5);
        rd(32'h014, d); chk(d, 32'h1);
        chk(irq, 1'b0);
        step(11, 11'h394);
        wait_idle();
        chk(irq, 1'b1);
        rd(32'h014, d); chk(d, 32'h7);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'b0);
        wr(32'h010, 32'h4); chk(rclosed, 1'b1);
        wr(32'h010, 32'h5);
        @(posedge core_clk);
        chk(rclosed, 1'b0);
    endtask

    task automatic t_imm();
        int p;
        int e;
        logic [31:0] d;
        p = n_tp;
        e = n_ep;
        wr(32'h018, 0); wr(32'h004, 2); wr(32'h000, 32'h01);
        wait_idle();
        chk(n_ep - e, 4);
        chk(n_tp - p, 0);
        rd(32'h01c, d); chk(d[31:16], 2);
        chk(irq, 1'b0);
        u_rss_bp_model.set_pf(1'b0);
        repeat (6) @(posedge core_clk);
        chk(rclosed, 1'b1);
        wr(32'h000, 32'h80);
        repeat (6) @(posedge core_clk);
        chk(rclosed, 1'b0);
        u_rss_bp_model.set_pf(1'b1);
    endtask

    task automatic t_cont();
        int e;
        logic [31:0] d;
        e = n_ep;
        wr(32'h004, 1); wr(32'h000, 32'h03);
        for (int i = 0; i < 3000 && n_ep < e + 5; i++) @(posedge core_clk);
        rd(32'h01c, d); chk(d[10:8] != 3'h0, 1);
        wr(32'h000, 32'h04);
        rd(32'h01c, d); chk(d[10:8], 3'h0);
        e = n_ep;
        repeat (200) @(posedge core_clk);
        chk(n_ep, e);
    endtask

    // Bus source: no step until the trigger strobe, then exactly one
    task automatic t_bus();
        int e;
        e = n_ep;
        wr(32'h000, 32'h11);
        repeat (200) @(posedge core_clk);
        chk(n_ep - e, 0);
        wr(32'h000, 32'h110);
        repeat (200) @(posedge core_clk);
        chk(n_ep - e, 1);
        wr(32'h000, 32'h04);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog against a hung wait
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_bp();
        t_imm();
        t_cont();
        t_bus();
        report_and_stop();
    end
endmodule
`default_nettype wire
